/* design/spba_top.sv */
// Two-wire serial port core: AHB-Lite registers on mclk, bus engine on lk_clk.
// Assumes open-drain pins resolved outside, lk_clk free running, srst held
// for at least three lk_clk periods.
//
// Behaviour
// - Bytes are shifted in and out of the shift register most significant bit first.
// - A complete received byte moves to the holding buffer and sets buffer-full and irq.
// - Reception of the next byte proceeds while the previous byte waits in the buffer.
// - A buffer write while a transfer is running is dropped and sets write-collision.
// - While write-collision is set, buffer writes are dropped until software clears it.
// - Reading the holding buffer clears buffer-full.
// - In multi-master mode, a released one sampled low with SCL high is a bus collision.
// - A collision in a data byte halts it, clears buffer-full and leaves the buffer writable.
// - A collision in start, restart, stop or ack aborts it and clears all five request bits.
// - After a collision the bus is still watched and a stop condition sets the irq flag.
// - After a collision a buffer write starts transmission from the first data bit.
// - Start and stop conditions on the bus are reported so software can tell it is free.
`timescale 1ns/100ps
module spba_top (
  // System
  input  wire logic        mclk,
  input  wire logic        srst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Link clock
  input  wire logic        lk_clk,
  // Two-wire pins
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  // Interrupt request
  output logic             bcol_irq
);

  typedef struct packed {
    logic                 rd_pend;
    logic                 wr_pend;
    logic [7:0]           addr;
    logic [31:0]          rdata;
    logic                 ready;
    logic [6:0]           ctrl;
    logic                 bcol_en;
    logic [7:0]           holdbuf;
    logic                 bf;
    logic                 irqf;
    logic                 write_collision_flag;
    logic                 bcol;
    logic                 ackin;
    logic                 busy;
    logic                 tx_req;
    spba_pkg::spba_op_t   op;
    logic [7:0]           txb;
    logic                 req_tgl;
    logic [1:0]           rsp_sync;
    logic                 rsp_seen;
    logic [1:0]           s_sync;
    logic [1:0]           p_sync;
    logic                 p_prev;
    logic                 irq_out;
  } spba_m_t;

  typedef struct packed {
    logic [1:0]           rst_sync;
    logic [1:0]           req_sync;
    logic                 req_seen;
    logic [1:0]           mm_sync;
    logic [1:0]           scl_sync;
    logic [1:0]           sda_sync;
    logic                 sda_prev;
    spba_pkg::spba_lk_state_t st;
    logic [2:0]           ph;
    logic [3:0]           nbit;
    logic [8:0]           ob;
    logic [8:0]           cm;
    logic [7:0]           sr;
    logic                 ackin;
    logic                 bcol;
    logic                 rsp_tgl;
    logic                 s_flag;
    logic                 p_flag;
    logic                 scl_oe_n;
    logic                 sda_oe_n;
  } spba_l_t;

  spba_m_t m_q;
  spba_m_t m_d;
  spba_l_t l_q;
  spba_l_t l_d;

  // Register side
  always_comb
  begin
    logic accept;
    logic rsp_ev;
    accept = hsel & htrans[1] & hready;
    rsp_ev = m_q.rsp_sync[1] != m_q.rsp_seen;
    m_d = m_q;
    m_d.rsp_sync = {m_q.rsp_sync[0], l_q.rsp_tgl};
    m_d.rsp_seen = m_q.rsp_sync[1];
    m_d.s_sync   = {m_q.s_sync[0], l_q.s_flag};
    m_d.p_sync   = {m_q.p_sync[0], l_q.p_flag};
    m_d.p_prev   = m_q.p_sync[1];
    m_d.wr_pend  = 1'b0;

    // Software actions first so that hardware events below win
    if (m_q.wr_pend)
    begin
      case (m_q.addr)
        spba_pkg::ADDR_CTRL: m_d.ctrl = hwdata[6:0];
        spba_pkg::ADDR_STAT:
        begin
          if (hwdata[spba_pkg::ST_IRQ])
            m_d.irqf = 1'b0;
          if (hwdata[spba_pkg::ST_WRITE_COLLISION_FLAG])
            m_d.write_collision_flag = 1'b0;
          if (hwdata[spba_pkg::ST_BCOL])
            m_d.bcol = 1'b0;
        end
        spba_pkg::ADDR_BUF:
        begin
          if (m_q.busy || m_q.tx_req || m_q.write_collision_flag)
            m_d.write_collision_flag = 1'b1;
          else
          begin
            m_d.holdbuf = hwdata[7:0];
            m_d.tx_req  = 1'b1;
            m_d.bf      = 1'b1;
          end
        end
        spba_pkg::ADDR_IEN: m_d.bcol_en = hwdata[spba_pkg::IEN_BCOL];
        default: ;
      endcase
    end

    if (m_q.rd_pend)
    begin
      m_d.rd_pend = 1'b0;
      m_d.ready   = 1'b1;
      case (m_q.addr)
        spba_pkg::ADDR_CTRL: m_d.rdata = {25'h0, m_q.ctrl};
        spba_pkg::ADDR_STAT:
          m_d.rdata = {24'h0, m_q.ackin, m_q.busy, m_q.p_sync[1], m_q.s_sync[1],
                       m_q.bcol, m_q.write_collision_flag, m_q.irqf, m_q.bf};
        spba_pkg::ADDR_BUF:
        begin
          m_d.rdata = {24'h0, m_q.holdbuf};
          m_d.bf    = 1'b0;
        end
        spba_pkg::ADDR_IEN: m_d.rdata = {31'h0, m_q.bcol_en};
        default: m_d.rdata = 32'h0;
      endcase
    end

    if (accept)
    begin
      m_d.addr = haddr[7:0];
      if (hwrite)
        m_d.wr_pend = 1'b1;
      else
      begin
        m_d.rd_pend = 1'b1;
        m_d.ready   = 1'b0;
      end
    end

    // Launch one operation at a time; data stay stable until the answer
    if (!m_q.busy)
    begin
      m_d.busy = 1'b1;
      if (m_q.ctrl[spba_pkg::CTL_START])
        m_d.op = spba_pkg::SPBA_OP_START;
      else if (m_q.ctrl[spba_pkg::CTL_RSTART])
        m_d.op = spba_pkg::SPBA_OP_RSTART;
      else if (m_q.ctrl[spba_pkg::CTL_STOP])
        m_d.op = spba_pkg::SPBA_OP_STOP;
      else if (m_q.ctrl[spba_pkg::CTL_ACK])
        m_d.op = spba_pkg::SPBA_OP_ACK;
      else if (m_q.ctrl[spba_pkg::CTL_RCV])
        m_d.op = spba_pkg::SPBA_OP_RCV;
      else if (m_q.tx_req)
        m_d.op = spba_pkg::SPBA_OP_TX;
      else
        m_d.busy = 1'b0;
      if (m_d.busy)
      begin
        m_d.req_tgl = ~m_q.req_tgl;
        m_d.txb     = (m_d.op == spba_pkg::SPBA_OP_ACK) ?
                      {m_q.ctrl[spba_pkg::CTL_ACKDT], 7'h0} : m_q.holdbuf;
      end
    end

    // Answer from the link
    if (rsp_ev)
    begin
      m_d.busy = 1'b0;
      m_d.irqf = 1'b1;
      case (m_q.op)
        spba_pkg::SPBA_OP_START:  m_d.ctrl[spba_pkg::CTL_START]  = 1'b0;
        spba_pkg::SPBA_OP_RSTART: m_d.ctrl[spba_pkg::CTL_RSTART] = 1'b0;
        spba_pkg::SPBA_OP_STOP:   m_d.ctrl[spba_pkg::CTL_STOP]   = 1'b0;
        spba_pkg::SPBA_OP_ACK:    m_d.ctrl[spba_pkg::CTL_ACK]    = 1'b0;
        spba_pkg::SPBA_OP_RCV:
        begin
          m_d.ctrl[spba_pkg::CTL_RCV] = 1'b0;
          m_d.holdbuf = l_q.sr;
          m_d.bf      = 1'b1;
        end
        spba_pkg::SPBA_OP_TX:
        begin
          m_d.tx_req = 1'b0;
          m_d.bf     = 1'b0;
          m_d.ackin  = l_q.ackin;
        end
        default: ;
      endcase
      if (l_q.bcol)
      begin
        m_d.bcol   = 1'b1;
        m_d.irqf   = m_q.irqf;
        m_d.bf     = 1'b0;
        m_d.tx_req = 1'b0;
        m_d.ctrl   = m_q.ctrl & ~spba_pkg::CTL_REQ_MASK;
      end
    end

    if (m_q.ctrl[spba_pkg::CTL_MM] && m_q.p_sync[1] && !m_q.p_prev)
      m_d.irqf = 1'b1;

    m_d.irq_out = m_q.bcol & m_q.bcol_en;

    if (srst)
    begin
      m_d       = '0;
      m_d.ready = spba_pkg::READY_RST;
      m_d.ctrl  = spba_pkg::CTRL_RST;
    end
  end

  always_ff @(posedge mclk)
    m_q <= m_d;

  // Link side
  always_comb
  begin
    logic sda_s;
    logic scl_s;
    logic collide;
    logic finish;
    sda_s   = l_q.sda_sync[1];
    scl_s   = l_q.scl_sync[1];
    collide = 1'b0;
    finish  = 1'b0;
    l_d = l_q;
    l_d.rst_sync = {l_q.rst_sync[0], srst};
    l_d.req_sync = {l_q.req_sync[0], m_q.req_tgl};
    l_d.mm_sync  = {l_q.mm_sync[0], m_q.ctrl[spba_pkg::CTL_MM]};
    l_d.scl_sync = {l_q.scl_sync[0], scl_i};
    l_d.sda_sync = {l_q.sda_sync[0], sda_i};
    l_d.sda_prev = sda_s;

    // Bus conditions, seen whether or not this end drives them
    if (scl_s && l_q.sda_prev && !sda_s)
    begin
      l_d.s_flag = 1'b1;
      l_d.p_flag = 1'b0;
    end
    else if (scl_s && !l_q.sda_prev && sda_s)
    begin
      l_d.p_flag = 1'b1;
      l_d.s_flag = 1'b0;
    end

    if (l_q.st != spba_pkg::SPBA_LK_IDLE)
      l_d.ph = l_q.ph + 3'h1;

    case (l_q.st)
      spba_pkg::SPBA_LK_IDLE:
      begin
        l_d.ph = spba_pkg::PH_DATA;
        if (l_q.req_sync[1] != l_q.req_seen)
        begin
          l_d.req_seen = l_q.req_sync[1];
          l_d.bcol     = 1'b0;
          l_d.cm       = 9'h0;
          l_d.ob       = spba_pkg::ALL_RELEASE;
          l_d.st       = spba_pkg::SPBA_LK_BITS;
          case (m_q.op)
            spba_pkg::SPBA_OP_START,
            spba_pkg::SPBA_OP_RSTART: l_d.st = spba_pkg::SPBA_LK_START;
            spba_pkg::SPBA_OP_STOP:   l_d.st = spba_pkg::SPBA_LK_STOP;
            spba_pkg::SPBA_OP_TX:
            begin
              l_d.ob   = {m_q.txb, 1'b1};
              l_d.cm   = spba_pkg::TX_CHECK;
              l_d.nbit = spba_pkg::TX_LAST_BIT;
            end
            spba_pkg::SPBA_OP_ACK:
            begin
              l_d.ob   = {m_q.txb[7], 8'hFF};
              l_d.cm   = spba_pkg::ACK_CHECK;
              l_d.nbit = 4'h0;
            end
            default: l_d.nbit = spba_pkg::RCV_LAST_BIT;
          endcase
        end
      end
      spba_pkg::SPBA_LK_START:
      begin
        case (l_q.ph)
          spba_pkg::PH_DATA: l_d.sda_oe_n = 1'b1;
          spba_pkg::PH_RISE: l_d.scl_oe_n = 1'b1;
          spba_pkg::PH_SAMP:
            if (l_q.mm_sync[1] && !sda_s)
              collide = 1'b1;
            else
              l_d.sda_oe_n = 1'b0;
          spba_pkg::PH_FALL:
          begin
            l_d.scl_oe_n = 1'b0;
            finish       = 1'b1;
          end
          default: ;
        endcase
      end
      spba_pkg::SPBA_LK_STOP:
      begin
        case (l_q.ph)
          spba_pkg::PH_DATA: l_d.sda_oe_n = 1'b0;
          spba_pkg::PH_RISE: l_d.scl_oe_n = 1'b1;
          spba_pkg::PH_FREE: l_d.sda_oe_n = 1'b1;
          spba_pkg::PH_FALL:
            if (l_q.mm_sync[1] && !sda_s)
              collide = 1'b1;
            else
              finish = 1'b1;
          default: ;
        endcase
      end
      spba_pkg::SPBA_LK_BITS:
      begin
        case (l_q.ph)
          spba_pkg::PH_DATA: l_d.sda_oe_n = l_q.ob[8];
          spba_pkg::PH_RISE: l_d.scl_oe_n = 1'b1;
          spba_pkg::PH_SAMP:
          begin
            l_d.sr    = {l_q.sr[6:0], sda_s};
            l_d.ackin = sda_s;
            if (l_q.mm_sync[1] && l_q.cm[8] && l_q.ob[8] && !sda_s)
              collide = 1'b1;
          end
          spba_pkg::PH_FALL:
          begin
            l_d.scl_oe_n = 1'b0;
            l_d.ob       = {l_q.ob[7:0], 1'b1};
            l_d.cm       = {l_q.cm[7:0], 1'b0};
            if (l_q.nbit == 4'h0)
              finish = 1'b1;
            else
              l_d.nbit = l_q.nbit - 4'h1;
          end
          default: ;
        endcase
      end
      default: l_d.st = spba_pkg::SPBA_LK_IDLE;
    endcase

    // Losing arbitration lets go of both lines at once
    if (collide)
    begin
      l_d.sda_oe_n = 1'b1;
      l_d.scl_oe_n = 1'b1;
      l_d.bcol     = 1'b1;
    end
    if (collide || finish)
    begin
      l_d.st      = spba_pkg::SPBA_LK_IDLE;
      l_d.rsp_tgl = ~l_q.rsp_tgl;
    end

    if (l_q.rst_sync[1])
    begin
      l_d          = '0;
      l_d.rst_sync = {l_q.rst_sync[0], srst};
      l_d.scl_oe_n = spba_pkg::RELEASE_RST;
      l_d.sda_oe_n = spba_pkg::RELEASE_RST;
      // Chains start at the idle high level, else release looks like a stop
      l_d.scl_sync = {2{spba_pkg::RELEASE_RST}};
      l_d.sda_sync = {2{spba_pkg::RELEASE_RST}};
      l_d.sda_prev = spba_pkg::RELEASE_RST;
    end
  end

  always_ff @(posedge lk_clk)
    l_q <= l_d;

  // Pins drive low only; the enables carry the level
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe_n  = l_q.scl_oe_n;
  assign sda_oe_n  = l_q.sda_oe_n;
  assign hrdata    = m_q.rdata;
  assign hreadyout = m_q.ready;
  assign hresp     = 1'b0;
  assign bcol_irq  = m_q.irq_out;

endmodule // spba_top

/* pkg/spba_pkg.sv */
// Constants and state types for the two-wire serial port core.
// Used by design/spba_top.sv; holds no logic.
package spba_pkg;

  // Register byte offsets, decoded from haddr[7:0]
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_BUF  = 8'h08;
  localparam logic [7:0] ADDR_IEN  = 8'h0C;

  // serial_control_reg_two bits
  localparam int CTL_MM     = 0;
  localparam int CTL_START  = 1;
  localparam int CTL_RSTART = 2;
  localparam int CTL_STOP   = 3;
  localparam int CTL_ACK    = 4;
  localparam int CTL_RCV    = 5;
  localparam int CTL_ACKDT  = 6;
  localparam logic [6:0] CTL_REQ_MASK = 7'h3E;

  // serial_status_reg bits
  localparam int ST_BF    = 0;
  localparam int ST_IRQ   = 1;
  localparam int ST_WRITE_COLLISION_FLAG  = 2;
  localparam int ST_BCOL  = 3;
  localparam int ST_START = 4;
  localparam int ST_STOP  = 5;
  localparam int ST_BUSY  = 6;
  localparam int ST_ACKIN = 7;

  // Interrupt enable register bit
  localparam int IEN_BCOL = 0;

  // Reset values
  localparam logic [6:0]  CTRL_RST    = 7'h00;
  localparam logic        READY_RST   = 1'b1;
  localparam logic        RELEASE_RST = 1'b1;

  // Link phases within one bit time (eight link clocks per bit)
  localparam logic [2:0] PH_DATA = 3'h0;
  localparam logic [2:0] PH_RISE = 3'h2;
  localparam logic [2:0] PH_FREE = 3'h4;
  localparam logic [2:0] PH_SAMP = 3'h5;
  localparam logic [2:0] PH_FALL = 3'h7;

  // Byte framing
  localparam logic [3:0] TX_LAST_BIT  = 4'h8;
  localparam logic [3:0] RCV_LAST_BIT = 4'h7;
  localparam logic [8:0] TX_CHECK     = 9'h1FE;
  localparam logic [8:0] ACK_CHECK    = 9'h100;
  localparam logic [8:0] ALL_RELEASE  = 9'h1FF;

  typedef enum logic [2:0] {
    SPBA_OP_START,
    SPBA_OP_RSTART,
    SPBA_OP_STOP,
    SPBA_OP_ACK,
    SPBA_OP_RCV,
    SPBA_OP_TX
  } spba_op_t;

  typedef enum logic [1:0] {
    SPBA_LK_IDLE,
    SPBA_LK_START,
    SPBA_LK_BITS,
    SPBA_LK_STOP
  } spba_lk_state_t;

endpackage

/* bench/spba_chk_sva.sv */
// Concurrent checks on the serial port core's top-level pins.
// Bound to spba_top; watches the bus on mclk and the wire engine on lk_clk.
`timescale 1ns/100ps
module spba_chk (
  // Clocks and reset
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        lk_clk,
  // Register bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Pins and interrupt
  input wire logic        scl_o,
  input wire logic        scl_oe_n,
  input wire logic        sda_o,
  input wire logic        sda_oe_n,
  input wire logic        bcol_irq
);
  logic       take;
  logic       rd_dp_q;
  logic [3:0] wr_hist_q;
  assign take = hsel && htrans[1] && hready;
  // Software is the only thing allowed to drop the collision request
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rd_dp_q   <= 1'b0;
      wr_hist_q <= 4'h0;
    end
    else
    begin
      rd_dp_q   <= take ? !hwrite : (rd_dp_q && !hready);
      wr_hist_q <= {wr_hist_q[2:0], take && hwrite};
    end
  end
  property p_okay;
    @(posedge mclk) disable iff (srst) hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_rd_wait;
    @(posedge mclk) disable iff (srst) take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_zero;
    @(posedge mclk) disable iff (srst) take && hwrite |=> hreadyout;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write stalled");
  property p_hold;
    @(posedge mclk) disable iff (srst) !(rd_dp_q && hreadyout) |-> $stable(hrdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved outside a read");
  property p_open;
    @(posedge mclk) disable iff (srst) scl_o == 1'b0 && sda_o == 1'b0;
  endproperty
  a_open: assert property (p_open) else $error("pin driven high");
  property p_irq_fall;
    @(posedge mclk) disable iff (srst) $fell(bcol_irq) |-> |wr_hist_q;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped with no write");
  property p_scl_up;
    @(posedge lk_clk) disable iff (srst) $rose(scl_oe_n) |-> scl_oe_n[*5];
  endproperty
  a_scl_up: assert property (p_scl_up) else $error("clock high phase too short");
  property p_scl_low;
    @(posedge lk_clk) disable iff (srst) $fell(scl_oe_n) |-> !scl_oe_n[*3];
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock low phase too short");
endmodule // spba_chk

bind spba_top spba_chk spba_chk_i (
  .mclk(mclk), .srst(srst), .lk_clk(lk_clk), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .bcol_irq(bcol_irq));

/* bench/spba_far_end.sv */
// Far-side model: a slave that acks, serves read bytes, and can pin SDA low.
// Sees the resolved wired-AND lines; pull-ups are made in the bench.
`timescale 1ns/100ps
module spba_far_end (
  // Resolved bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  // Scenario controls
  input  wire logic       rd_mode,
  input  wire logic [7:0] rd_byte,
  input  wire logic       hold_low,
  // Model outputs
  output logic            sda_pull,
  output logic [7:0]      got
);
  int k = 9;
  initial got = 8'h00;
  always @(negedge sda) if (scl) k = -1;
  always @(posedge sda) if (scl) k = 9;
  always @(negedge scl) k = (k >= 8) ? 0 : k + 1;
  always @(posedge scl) if (!rd_mode && k >= 0 && k < 8) got = {got[6:0], sda};
  // Another master holding SDA low is how collisions are made
  assign sda_pull = hold_low || (!rd_mode && k == 8) ||
                    (rd_mode && k >= 0 && k < 8 && !rd_byte[7 - k]);
endmodule // spba_far_end

/* bench/testbench.sv */
// Self-checking bench for the two-wire serial port core.
// AHB-Lite master on mclk, free link clock, far-side model on open-drain lines.
`timescale 1ns/100ps
module testbench;
  logic        mclk = 1'b0;
  logic        lk_clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, scl_o, scl_oe_n, sda_o, sda_oe_n, bcol_irq, sda_pull;
  logic        rd_mode = 1'b0;
  logic [7:0]  rd_byte = 8'h00;
  logic        hold_low = 1'b0;
  logic [7:0]  got;
  logic [31:0] r;
  logic        scl;
  logic        sda;
  int          miscompares = 0;
  int          n_checks = 0;
  // Released lines float to the pull-up level
  assign scl = scl_oe_n ? 1'b1 : scl_o;
  assign sda = (sda_oe_n ? 1'b1 : sda_o) && !sda_pull;
  initial forever #2.5 mclk = ~mclk;
  initial
  begin
    #37;
    forever #80 lk_clk = ~lk_clk;
  end
  spba_top spba_top_i (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lk_clk(lk_clk),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .bcol_irq(bcol_irq));
  spba_far_end spba_far_end_i (.scl(scl), .sda(sda), .rd_mode(rd_mode),
    .rd_byte(rd_byte), .hold_low(hold_low), .sda_pull(sda_pull), .got(got));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // Poll until idle (busy bit and control request bits clear) or until the given status bit is set
  task automatic wait_for(input int bitn);
    logic [6:0] req;
    for (int i = 0; i < 2000; i++)
    begin
      ahb(1'b0, spba_pkg::ADDR_CTRL, 32'h0);
      req = r[6:0] & spba_pkg::CTL_REQ_MASK;
      ahb(1'b0, spba_pkg::ADDR_STAT, 32'h0);
      if (bitn == spba_pkg::ST_BUSY ? (req === 7'h00 && r[bitn] === 1'b0) : r[bitn] === 1'b1)
        return;
    end
    chk(32'h0, 32'h1);
  endtask
  task automatic t_reset;
    // Let the link side leave its own reset before bus conditions are read
    repeat (200) @(posedge mclk);
    ahb(1'b0, spba_pkg::ADDR_STAT, 32'h0);
    chk(r & 32'h7F, 32'h0);
    ahb(1'b0, spba_pkg::ADDR_CTRL, 32'h0);
    chk(r, {25'h0, spba_pkg::CTRL_RST});
    ahb(1'b1, 8'h10, 32'hFFFFFFFF);
    ahb(1'b0, 8'h10, 32'h0);
    chk(r, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_tx;
    ahb(1'b1, spba_pkg::ADDR_CTRL, 32'h3);
    wait_for(spba_pkg::ST_BUSY);
    ahb(1'b1, spba_pkg::ADDR_BUF, 32'hA5);
    ahb(1'b1, spba_pkg::ADDR_BUF, 32'h3C);
    ahb(1'b0, spba_pkg::ADDR_STAT, 32'h0);
    chk({30'h0, r[spba_pkg::ST_WRITE_COLLISION_FLAG], r[spba_pkg::ST_BF]}, 32'h3);
    wait_for(spba_pkg::ST_BUSY);
    chk({24'h0, got}, 32'hA5);
    ahb(1'b1, spba_pkg::ADDR_BUF, 32'h55);
    ahb(1'b0, spba_pkg::ADDR_STAT, 32'h0);
    chk({30'h0, r[spba_pkg::ST_BUSY], r[spba_pkg::ST_WRITE_COLLISION_FLAG]}, 32'h1);
    ahb(1'b1, spba_pkg::ADDR_STAT, 32'h6);
    ahb(1'b1, spba_pkg::ADDR_BUF, 32'h55);
    wait_for(spba_pkg::ST_BUSY);
    chk({24'h0, got}, 32'h55);
    ahb(1'b1, spba_pkg::ADDR_CTRL, 32'h5);
    wait_for(spba_pkg::ST_BUSY);
    ahb(1'b0, spba_pkg::ADDR_STAT, 32'h0);
    chk({30'h0, r[spba_pkg::ST_ACKIN], r[spba_pkg::ST_START]}, 32'h1);
    $display("transmit test done");
  endtask
  task automatic t_rx;
    rd_byte = 8'hC3;
    rd_mode = 1'b1;
    ahb(1'b1, spba_pkg::ADDR_STAT, 32'h2);
    ahb(1'b1, spba_pkg::ADDR_CTRL, 32'h21);
    wait_for(spba_pkg::ST_BUSY);
    ahb(1'b0, spba_pkg::ADDR_STAT, 32'h0);
    chk({30'h0, r[spba_pkg::ST_IRQ], r[spba_pkg::ST_BF]}, 32'h3);
    rd_byte = 8'h3A;
    ahb(1'b1, spba_pkg::ADDR_CTRL, 32'h31);
    ahb(1'b0, spba_pkg::ADDR_BUF, 32'h0);
    chk(r, 32'hC3);
    ahb(1'b0, spba_pkg::ADDR_STAT, 32'h0);
    chk({31'h0, r[spba_pkg::ST_BF]}, 32'h0);
    wait_for(spba_pkg::ST_BUSY);
    ahb(1'b0, spba_pkg::ADDR_BUF, 32'h0);
    chk(r, 32'h3A);
    ahb(1'b1, spba_pkg::ADDR_CTRL, 32'h9);
    wait_for(spba_pkg::ST_BUSY);
    rd_mode = 1'b0;
    ahb(1'b0, spba_pkg::ADDR_STAT, 32'h0);
    chk({31'h0, r[spba_pkg::ST_STOP]}, 32'h1);
    $display("receive test done");
  endtask
  task automatic t_col;
    ahb(1'b1, spba_pkg::ADDR_IEN, 32'h1);
    ahb(1'b1, spba_pkg::ADDR_STAT, 32'hE);
    hold_low = 1'b1;
    ahb(1'b1, spba_pkg::ADDR_CTRL, 32'h3);
    wait_for(spba_pkg::ST_BCOL);
    ahb(1'b0, spba_pkg::ADDR_CTRL, 32'h0);
    chk(r & 32'h3E, 32'h0);
    chk({29'h0, scl_oe_n, sda_oe_n, bcol_irq}, 32'h7);
    hold_low = 1'b0;
    wait_for(spba_pkg::ST_IRQ);
    ahb(1'b1, spba_pkg::ADDR_STAT, 32'hA);
    repeat (4) @(posedge mclk);
    chk({31'h0, bcol_irq}, 32'h0);
    ahb(1'b1, spba_pkg::ADDR_CTRL, 32'h3);
    wait_for(spba_pkg::ST_BUSY);
    ahb(1'b1, spba_pkg::ADDR_STAT, 32'h2);
    hold_low = 1'b1;
    ahb(1'b1, spba_pkg::ADDR_BUF, 32'hFF);
    wait_for(spba_pkg::ST_BCOL);
    ahb(1'b0, spba_pkg::ADDR_STAT, 32'h0);
    chk({30'h0, r[spba_pkg::ST_BUSY], r[spba_pkg::ST_BF]}, 32'h0);
    chk({30'h0, scl_oe_n, sda_oe_n}, 32'h3);
    hold_low = 1'b0;
    wait_for(spba_pkg::ST_IRQ);
    ahb(1'b1, spba_pkg::ADDR_STAT, 32'hA);
    ahb(1'b1, spba_pkg::ADDR_CTRL, 32'h3);
    wait_for(spba_pkg::ST_BUSY);
    ahb(1'b1, spba_pkg::ADDR_BUF, 32'h96);
    wait_for(spba_pkg::ST_BUSY);
    chk({24'h0, got}, 32'h96);
    $display("collision test done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Roughly five times the expected run length
  initial
  begin
    #400000;
    chk(32'h0, 32'h1);
    complete_run;
  end
  // Reset spans several link clocks so the engine sees it
  initial
  begin
    repeat (12) @(posedge lk_clk);
    @(posedge mclk);
    srst <= 1'b0;
    t_reset;
    t_tx;
    t_rx;
    t_col;
    complete_run;
  end
endmodule // testbench
